// ---- common/ltc_pkg.sv ----
// Constants, types and helpers shared by the linearize, trim and clamp path
package ltc_pkg;

  // ------------------------------------------------------------------
  // Configuration word addresses
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_CLAMP     = 7'h08;
  localparam logic [6:0] ADDR_LIN_FIRST = 7'h0a;
  localparam logic [6:0] ADDR_LIN_LAST  = 7'h12;
  localparam logic [6:0] ADDR_TRIM      = 7'h13;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int ADDR_W     = 7;
  localparam int WORD_W     = 26;
  localparam int TRIM_W     = 24;
  localparam int LIN_WORDS  = 9;
  localparam int COEF_COUNT = 17;
  localparam int BIN_COUNT  = 8;
  localparam int COEF_W     = 13;
  localparam int CODE_W     = 12;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 13;
  localparam int CTL_BIN_BIT    = 14;
  localparam int CTL_OUTINV_BIT = 15;
  localparam int CTL_ININV_BIT  = 16;
  localparam int CTL_HYST_LSB   = 17;
  localparam int CTL_HYST_MSB   = 24;
  localparam int CTL_SCALE_BIT  = 25;
  localparam int ODD_ENTRY_LSB  = 13;
  localparam int GAIN_LSB       = 0;
  localparam int OFFSET_LSB     = 12;
  localparam int UPPER_LSB      = 0;
  localparam int LOWER_LSB      = 12;

  // ------------------------------------------------------------------
  // Arithmetic constants and reset values
  // ------------------------------------------------------------------
  localparam int                 SEG_SHIFT     = 12;
  localparam int                 GAIN_FRAC     = 11;
  localparam int                 COARSE_SHIFT  = 4;
  localparam int                 LOC_SHIFT     = 3;
  localparam int                 LIN_SHIFT     = 2;
  localparam logic signed [17:0] LOC_BIAS      = 18'sh01000;
  localparam logic [15:0]        UNSIGNED_BIAS = 16'h8000;
  localparam logic [11:0]        CODE_MAX      = 12'hfff;
  localparam logic [15:0]        CLAMP_TOP     = 16'hffff;
  localparam logic [WORD_W-1:0]  WORD_RESET    = 26'h0000000;
  localparam logic [TRIM_W-1:0]  TRIM_RESET    = 24'h000000;

  typedef logic signed [15:0] ltc_sample_t;

  // Saturate a wide signed value to the 16-bit signed sample range
  function automatic ltc_sample_t ltc_sat16(input logic signed [19:0] v);
    ltc_sample_t r;
    if (v > 20'sh07fff) begin
      r = 16'sh7fff;
    end else if (v < -20'sh08000) begin
      r = -16'sh8000;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

endpackage

// ---- common/ltc_stage_if.sv ----
// Hand-off between the correction stage and the trim/clamp stage
`timescale 1ns/1ps
interface ltc_stage_if;
  import ltc_pkg::*;
  logic        valid;
  ltc_sample_t y3;
  logic [11:0] gainCode;
  logic [11:0] offsetCode;
  logic [11:0] upperCode;
  logic [11:0] lowerCode;
  logic        outValid;
  logic [15:0] outValue;

  modport src (output valid, y3, gainCode, offsetCode, upperCode, lowerCode,
               input outValid, outValue);
  modport dst (input valid, y3, gainCode, offsetCode, upperCode, lowerCode,
               output outValid, outValue);
endinterface

// ---- hdl/ltc_trim_clamp.sv ----
// Post-correction gain/offset trim followed by unsigned conversion and clamp
`timescale 1ns/1ps
module ltc_trim_clamp (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clkEn,
  ltc_stage_if.dst  stg
);
  import ltc_pkg::*;

  typedef struct packed {
    logic        v4;
    ltc_sample_t y4;
    logic        vOut;
    logic [15:0] out;
  } ltc_tc_state_t;

  ltc_tc_state_t q;
  ltc_tc_state_t d;

  logic signed [27:0] prod;
  logic signed [19:0] sum;
  logic [15:0]        y5;
  logic [15:0]        upper;
  logic [15:0]        lower;

  always_comb begin
    d    = q;
    prod = 28'(stg.y3) * 28'($signed(stg.gainCode));
    // Wide sum so that the trim overflow saturates, see RULE_23
    sum  = 20'(stg.y3) + 20'(prod >>> GAIN_FRAC)
         + (20'($signed(stg.offsetCode)) <<< COARSE_SHIFT);            // see RULE_11
    d.v4 = stg.valid;
    // Trim and clamp only on a result, so the output holds between samples
    if (stg.valid) begin
      d.y4 = ltc_sat16(sum);                                           // see RULE_23
    end
    y5   = 16'(unsigned'(q.y4) + UNSIGNED_BIAS);                       // see RULE_14
    // Upper code n means (n+1)*16, topping out at full scale
    upper = (stg.upperCode == CODE_MAX) ? CLAMP_TOP
          : {12'(stg.upperCode + 12'h001), 4'h0};                      // see RULE_17
    lower = {stg.lowerCode, 4'h0};                                     // see RULE_18
    d.vOut = q.v4;
    // Upper test first keeps crossed limits deterministic, see RULE_22
    if (!q.v4) begin
      d.out = q.out;
    end else if (y5 > upper) begin
      d.out = upper;                                                   // see RULE_15
    end else if (y5 < lower) begin
      d.out = lower;                                                   // see RULE_16
    end else begin
      d.out = y5;                                                      // see RULE_16
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign stg.outValid = q.vOut;
  assign stg.outValue = q.out;

endmodule

// ---- hdl/ltc_lin_path.sv ----
// Sample correction path: configuration words, 17-point table, trim and clamp
//
// What this block does
// RULE_01: Interpolating mode uses 17 coefficients at equally spaced points over the input span.
// RULE_02: Binning mode produces a discrete level per bin instead of interpolating.
// RULE_03: Bin x output is coefficient x between its hysteresis threshold and next boundary.
// RULE_04: Bin hysteresis applies only while the input is falling, zero when rising.
// RULE_05: Control bit 13 enables the correction table; clear bypasses it.
// RULE_06: Control bit 14 selects binning mode, else interpolating mode.
// RULE_07: Control bit 15 inverts the value leaving the correction stage.
// RULE_08: Control bit 16 inverts the value entering the correction stage.
// RULE_09: Control bits 24:17 hold the bin hysteresis in steps of two LSBs.
// RULE_10: Control bit 25 doubles every coefficient before use.
// RULE_11: Trim output is corrected value times one plus gain, plus offset, 16-bit signed.
// RULE_12: Gain is trim word bits 11:0, signed, step two to the minus eleven.
// RULE_13: Offset is trim word bits 23:12, signed, sixteen LSB steps.
// RULE_14: Trimmed value becomes unsigned by adding 32768 before limit compares.
// RULE_15: Above the upper limit the output is the upper limit.
// RULE_16: Below the lower limit the output is the lower limit, else unchanged.
// RULE_17: Upper limit is clamp word bits 11:0 in sixteen LSB steps, up to 65535.
// RULE_18: Lower limit is clamp word bits 23:12 in sixteen LSB steps, 0 to 65520.
// RULE_19: Interpolating mode interpolates linearly between adjacent points.
// RULE_20: Bin locations are 13-bit unsigned, input divided by eight plus 4096.
// RULE_21: Unscaled interpolating coefficients span a quarter of the full output range.
// RULE_22: Upper limit comparison is evaluated first when limits are crossed.
// RULE_23: Trim arithmetic saturates at the 16-bit signed limits instead of wrapping.
`timescale 1ns/1ps
module ltc_lin_path (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          clkEn,
  input  wire logic                          sampleValid,
  input  wire ltc_pkg::ltc_sample_t          sampleIn,
  input  wire logic                          cfgWrEn,
  input  wire logic [ltc_pkg::ADDR_W-1:0]    cfgAddr,
  input  wire logic [ltc_pkg::WORD_W-1:0]    cfgWrData,
  input  wire logic                          cfgRdEn,
  output logic      [ltc_pkg::WORD_W-1:0]    cfgRdData,
  output logic                               outValid,
  output logic      [15:0]                   outSample
);
  import ltc_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [LIN_WORDS-1:0][WORD_W-1:0] lin;
    logic [TRIM_W-1:0]                clampW;
    logic [TRIM_W-1:0]                trimW;
    logic [WORD_W-1:0]                rd;
    logic                             v1;
    ltc_sample_t                      y2;
    ltc_sample_t                      prevY2;
    logic                             dec1;
    logic                             v2;
    ltc_sample_t                      y3;
  } ltc_lp_state_t;

  ltc_lp_state_t q;
  ltc_lp_state_t d;

  // ------------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] ctlW;
  logic              corrEn;
  logic              binMode;
  logic              outInv;
  logic              inInv;
  logic [7:0]        hyst;
  logic              scale;

  assign ctlW    = q.lin[LIN_WORDS-1];
  assign corrEn  = ctlW[CTL_ENABLE_BIT];                    // see RULE_05
  assign binMode = ctlW[CTL_BIN_BIT];                       // see RULE_06
  assign outInv  = ctlW[CTL_OUTINV_BIT];
  assign inInv   = ctlW[CTL_ININV_BIT];
  assign hyst    = ctlW[CTL_HYST_MSB:CTL_HYST_LSB];         // see RULE_09
  assign scale   = ctlW[CTL_SCALE_BIT];

  // ------------------------------------------------------------------
  // Table entries, two per word, last one alone in the control word
  // ------------------------------------------------------------------
  logic [COEF_COUNT-1:0][COEF_W-1:0] entry;

  // ------------------------------------------------------------------
  // Bin thresholds, one per location entry
  // ------------------------------------------------------------------
  logic signed [17:0]    hystTerm;
  logic signed [17:0]    y2Wide;
  logic signed [17:0]    thr [BIN_COUNT];
  logic [BIN_COUNT-1:0]  above;

  // Falling input widens the window downward; rising input sees none
  assign hystTerm = q.dec1 ? $signed({9'h000, hyst, 1'b0}) : 18'sh00000;  // see RULE_04
  assign y2Wide   = 18'(q.y2);

  for (genvar e = 0; e < COEF_COUNT; e++) begin : g_entry
    if (e % 2 == 1) begin : g_odd
      assign entry[e] = q.lin[e / 2][ODD_ENTRY_LSB +: COEF_W];
    end else begin : g_even
      assign entry[e] = q.lin[e / 2][COEF_W-1:0];
    end
    if (e < BIN_COUNT) begin : g_bin
      // Location back to signed input scale, then lowered by hysteresis
      assign thr[e]   = (($signed({5'h00, entry[e]}) - LOC_BIAS) <<< LOC_SHIFT)
                      - hystTerm;                                         // see RULE_20
      assign above[e] = y2Wide > thr[e];                                  // see RULE_03
    end
  end

  // ------------------------------------------------------------------
  // Interpolating mode
  // ------------------------------------------------------------------
  logic [15:0]        ub;
  logic [3:0]         seg;
  logic [11:0]        frac;
  logic [COEF_W-1:0]  c0;
  logic [COEF_W-1:0]  c1;
  logic signed [13:0] diff;
  logic signed [26:0] prodI;
  logic signed [13:0] interp;
  logic signed [17:0] delta;
  ltc_sample_t        linY3;

  always_comb begin
    // Sixteen equal segments over the full span, 4096 counts each
    ub     = unsigned'(q.y2) ^ UNSIGNED_BIAS;                             // see RULE_01
    seg    = ub[15:SEG_SHIFT];
    frac   = ub[SEG_SHIFT-1:0];
    c0     = entry[seg];
    c1     = entry[5'({1'b0, seg} + 5'h01)];
    diff   = 14'($signed(c1)) - 14'($signed(c0));
    prodI  = 27'(diff) * 27'($signed({1'b0, frac}));                      // see RULE_19
    interp = 14'(27'($signed(c0)) + (prodI >>> SEG_SHIFT));
    // Four output LSBs per coefficient LSB gives a quarter of full scale
    delta  = scale ? (18'(interp) <<< (LIN_SHIFT + 1))                    // see RULE_10
                   : (18'(interp) <<< LIN_SHIFT);                         // see RULE_21
    linY3  = ltc_sat16(20'(q.y2) + 20'(delta));
  end

  // ------------------------------------------------------------------
  // Binning mode
  // ------------------------------------------------------------------
  logic               anyAbove;
  logic [2:0]         binIdx;
  logic [COEF_W-1:0]  binCoef;
  logic signed [17:0] binLevel;
  ltc_sample_t        binY3;

  always_comb begin
    anyAbove = 1'b0;
    binIdx   = 3'h0;
    // Highest crossed threshold wins, so the last bin covers the top
    for (int x = 0; x < BIN_COUNT; x++) begin
      if (above[x]) begin
        anyAbove = 1'b1;
        binIdx   = 3'(x);
      end
    end
    binCoef  = entry[5'({2'h0, binIdx} + 5'(BIN_COUNT))];
    binLevel = scale ? (($signed({5'h00, binCoef}) - LOC_BIAS) <<< (LOC_SHIFT + 1))
                     : (($signed({5'h00, binCoef}) - LOC_BIAS) <<< LOC_SHIFT);  // see RULE_10
    if (anyAbove) begin
      binY3 = ltc_sat16(20'(binLevel));                                   // see RULE_03
    end else if (entry[0] != 13'h0000) begin
      binY3 = -16'sh8000;                                                 // see RULE_03
    end else begin
      binY3 = ltc_sat16(20'(binLevel));
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  ltc_sample_t corrY3;
  ltc_sample_t inY2;

  always_comb begin
    d = q;

    // Configuration words
    if (cfgWrEn) begin
      if (cfgAddr == ADDR_CLAMP) begin
        d.clampW = cfgWrData[TRIM_W-1:0];
      end else if (cfgAddr == ADDR_TRIM) begin
        d.trimW = cfgWrData[TRIM_W-1:0];
      end else if (cfgAddr >= ADDR_LIN_FIRST && cfgAddr <= ADDR_LIN_LAST) begin
        d.lin[4'(cfgAddr - ADDR_LIN_FIRST)] = cfgWrData;
      end
    end
    // Unmapped reads return zero
    if (cfgRdEn) begin
      if (cfgAddr == ADDR_CLAMP) begin
        d.rd = WORD_W'(q.clampW);
      end else if (cfgAddr == ADDR_TRIM) begin
        d.rd = WORD_W'(q.trimW);
      end else if (cfgAddr >= ADDR_LIN_FIRST && cfgAddr <= ADDR_LIN_LAST) begin
        d.rd = q.lin[4'(cfgAddr - ADDR_LIN_FIRST)];
      end else begin
        d.rd = WORD_RESET;
      end
    end

    // Stage 1: optional input inversion and fall detection
    inY2 = (corrEn && inInv) ? ltc_sat16(-20'(sampleIn)) : sampleIn;   // see RULE_08
    d.v1 = sampleValid;
    if (sampleValid) begin
      d.y2     = inY2;
      d.prevY2 = inY2;
      d.dec1   = inY2 < q.prevY2;                                       // see RULE_04
    end

    // Stage 2: correction, mode select and output inversion
    corrY3 = binMode ? binY3 : linY3;                                   // see RULE_02
    d.v2   = q.v1;
    if (q.v1) begin
      if (!corrEn) begin
        d.y3 = q.y2;                                                    // see RULE_05
      end else if (outInv) begin
        d.y3 = ltc_sat16(-20'(corrY3));                                 // see RULE_07
      end else begin
        d.y3 = corrY3;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Trim and clamp stage
  // ------------------------------------------------------------------
  ltc_stage_if stg ();

  assign stg.valid      = q.v2;
  assign stg.y3         = q.y3;
  assign stg.gainCode   = q.trimW[GAIN_LSB +: CODE_W];                  // see RULE_12
  assign stg.offsetCode = q.trimW[OFFSET_LSB +: CODE_W];                // see RULE_13
  assign stg.upperCode  = q.clampW[UPPER_LSB +: CODE_W];                // see RULE_17
  assign stg.lowerCode  = q.clampW[LOWER_LSB +: CODE_W];                // see RULE_18

  ltc_trim_clamp u_trim_clamp (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .stg     (stg)
  );

  assign cfgRdData = q.rd;
  assign outValid  = stg.outValid;
  assign outSample = stg.outValue;

endmodule

// ---- bench/ltc_lin_path_assertions.sv ----
// Concurrent checks on the ports of the correction, trim and clamp path
`timescale 1ns/1ps
module ltc_lin_path_assertions (
  input wire logic                       ref_clk,
  input wire logic                       reset,
  input wire logic                       clkEn,
  input wire logic                       sampleValid,
  input wire ltc_pkg::ltc_sample_t       sampleIn,
  input wire logic                       cfgWrEn,
  input wire logic [ltc_pkg::ADDR_W-1:0] cfgAddr,
  input wire logic [ltc_pkg::WORD_W-1:0] cfgWrData,
  input wire logic                       cfgRdEn,
  input wire logic [ltc_pkg::WORD_W-1:0] cfgRdData,
  input wire logic                       outValid,
  input wire logic [15:0]                outSample
);
  import ltc_pkg::*;
  // ----------------------------------------------------------------
  // Shadow copies of the words the checks depend on
  // ----------------------------------------------------------------
  logic [23:0] clampSh_q;
  logic [25:0] ctlSh_q;
  logic [23:0] trimSh_q;
  logic [16:0] upLim;
  logic [16:0] loLim;
  logic        mapped;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clampSh_q <= '0;
      ctlSh_q   <= '0;
      trimSh_q  <= '0;
    end else if (clkEn && cfgWrEn) begin
      if (cfgAddr == ADDR_CLAMP) clampSh_q <= cfgWrData[23:0];
      if (cfgAddr == ADDR_LIN_LAST) ctlSh_q <= cfgWrData;
      if (cfgAddr == ADDR_TRIM) trimSh_q <= cfgWrData[23:0];
    end
  end
  assign upLim  = (clampSh_q[11:0] == CODE_MAX) ? 17'h0ffff : 17'({clampSh_q[11:0], 4'h0}) + 17'h10;
  assign loLim  = 17'({clampSh_q[23:12], 4'h0});
  assign mapped = cfgAddr == ADDR_CLAMP || cfgAddr == ADDR_TRIM
                  || (cfgAddr >= ADDR_LIN_FIRST && cfgAddr <= ADDR_LIN_LAST);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_out_latency: assert property (sampleValid && clkEn ##1 clkEn[*3] |=> outValid)
    else $error("result missing after four enabled edges");
  chk_no_extra: assert property (!sampleValid && clkEn ##1 clkEn[*3] |=> !outValid)
    else $error("result without a sample");
  chk_frozen_pipe: assert property (!clkEn |=> $stable(outSample)
    && $stable(outValid) && $stable(cfgRdData))
    else $error("state moved while clock enable low");
  chk_hold_result: assert property (!outValid && !$past(reset) |-> $stable(outSample))
    else $error("output changed without a result");
  chk_rd_unmapped: assert property (clkEn && cfgRdEn && !mapped |=> cfgRdData == '0)
    else $error("unmapped read not zero");
  chk_rd_hold: assert property (!(clkEn && cfgRdEn) |=> $stable(cfgRdData))
    else $error("read data moved without a read");
  chk_rd_clamp: assert property (clkEn && cfgRdEn && cfgAddr == ADDR_CLAMP
    |=> cfgRdData == {2'h0, $past(clampSh_q)})
    else $error("clamp word read back wrong");
  chk_rd_ctl: assert property (clkEn && cfgRdEn && cfgAddr == ADDR_LIN_LAST
    |=> cfgRdData == $past(ctlSh_q))
    else $error("control word read back wrong");
  chk_clamp_window: assert property (outValid && loLim <= upLim
    |-> {1'b0, outSample} <= upLim && {1'b0, outSample} >= loLim)
    else $error("output outside clamp window");
  chk_bypass_path: assert property (sampleValid && clkEn
    && !ctlSh_q[CTL_ENABLE_BIT] && trimSh_q == '0 && clampSh_q == 24'h000fff ##1 clkEn[*3]
    |=> outSample == $past(sampleIn, 4) + UNSIGNED_BIAS)
    else $error("bypass result not sample plus bias");
  cov_result: cover property (sampleValid && clkEn ##1 clkEn[*3] ##1 outValid);
  cov_upper: cover property (outValid && {1'b0, outSample} == upLim);
  cov_unmapped: cover property (clkEn && cfgRdEn && !mapped);
  cov_bin: cover property (outValid && ctlSh_q[CTL_BIN_BIT]);
endmodule

bind ltc_lin_path ltc_lin_path_assertions chk_u (.ref_clk, .reset, .clkEn, .sampleValid,
  .sampleIn, .cfgWrEn, .cfgAddr, .cfgWrData, .cfgRdEn, .cfgRdData, .outValid, .outSample);

// ---- bench/ltc_src_model.sv ----
// Upstream compensation stage model presenting one sample per enabled edge
`timescale 1ns/1ps
module ltc_src_model (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 clkEn,
  input  wire logic                 reqValid,
  input  wire ltc_pkg::ltc_sample_t reqSample,
  output logic                      sampleValid,
  output ltc_pkg::ltc_sample_t      sampleIn
);
  import ltc_pkg::*;
  // Idle bus toggles so a stale value never passes for a sample
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sampleValid <= 1'b0;
      sampleIn    <= 16'h5a5a;
    end else if (clkEn) begin
      sampleValid <= reqValid;
      sampleIn    <= reqValid ? reqSample : ~sampleIn;
    end
  end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the correction, trim and clamp path
`timescale 1ns/1ps
module testbench;
  import ltc_pkg::*;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic              clkEn = 1'b1;
  logic              stall = 1'b0;
  logic              reqValid = 1'b0;
  ltc_sample_t       reqSample = '0;
  logic              sampleValid;
  ltc_sample_t       sampleIn;
  logic              cfgWrEn = 1'b0;
  logic [ADDR_W-1:0] cfgAddr = '0;
  logic [WORD_W-1:0] cfgWrData = '0;
  logic              cfgRdEn = 1'b0;
  logic [WORD_W-1:0] cfgRdData;
  logic              outValid;
  logic [15:0]       outSample;
  logic [15:0]       expQ[$];
  logic [WORD_W-1:0] ctl;
  int                seed = 13;
  int                fail_count = 0;
  int                total_checks = 0;
  int                gain, offs, upC, loC, prevS;

  always #4 ref_clk = ~ref_clk;
  // Random stalls only while streaming; config writes need the enable
  always @(posedge ref_clk) clkEn <= stall ? (($random(seed) & 3) != 0) : 1'b1;

  ltc_src_model src_u (.ref_clk, .reset, .clkEn, .reqValid, .reqSample, .sampleValid, .sampleIn);
  ltc_lin_path dut_u (.ref_clk, .reset, .clkEn, .sampleValid, .sampleIn, .cfgWrEn, .cfgAddr,
    .cfgWrData, .cfgRdEn, .cfgRdData, .outValid, .outSample);

  // ----------------------------------------------------------------
  // Reference arithmetic
  // ----------------------------------------------------------------
  function automatic int sat(int v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction
  function automatic logic [15:0] finish5(int y3);
    int y, hi, lo;
    y = sat(y3 + ((y3 * gain) >>> 11) + offs * 16);
    hi = (upC == 4095) ? 65535 : (upC + 1) * 16;
    lo = loC * 16;
    y = y + 32768;
    return 16'(y > hi ? hi : (y < lo ? lo : y));
  endfunction
  function automatic int interp(int s);
    int c;
    if (ctl[CTL_ININV_BIT]) s = sat(-s);
    c = (s + 32768) >>> 8;
    s = sat(s + c * (ctl[CTL_SCALE_BIT] ? 8 : 4));
    return ctl[CTL_OUTINV_BIT] ? sat(-s) : s;
  endfunction
  function automatic int binRef(int s);
    int y;
    y = -32768;
    for (int x = 0; x < 8; x++)
      if (s > 4096 * x - (s < prevS ? 100 : 0)) y = 800 * x;
    return y;
  endfunction

  // ----------------------------------------------------------------
  // Drivers, checks and closing
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [25:0] e, logic [25:0] g);
    total_checks++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(logic [6:0] a, logic [25:0] d);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgWrData <= d;
    @(posedge ref_clk);
    cfgWrEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [6:0] a, logic [25:0] e);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge ref_clk);
    cfgRdEn <= 1'b0;
    @(posedge ref_clk);
    chk("cfgRdData", e, cfgRdData);
  endtask
  task automatic setTrim(int g, int o);
    gain = g;
    offs = o;
    wr(ADDR_TRIM, 26'({12'(o), 12'(g)}));
  endtask
  task automatic setClamp(int u, int l);
    upC = u;
    loC = l;
    wr(ADDR_CLAMP, 26'({12'(l), 12'(u)}));
  endtask
  // Request held until an enabled edge has taken it
  task automatic send(int s, int y3);
    int n = 0;
    reqValid <= 1'b1;
    reqSample <= 16'(s);
    expQ.push_back(finish5(y3));
    prevS = s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!clkEn && n < 50);
    if (n >= 50) fail_count++;
    if (n >= 50) results();
  endtask
  task automatic drain;
    int n = 0;
    reqValid <= 1'b0;
    stall <= 1'b0;
    while (expQ.size() != 0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300) fail_count++;
    if (n >= 300) results();
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic burst(int mode);
    int s;
    stall <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      s = (k == 0) ? 32767 : (k == 1) ? -32768 : $signed(16'($random(seed)));
      send(s, mode == 0 ? s : mode == 1 ? interp(s) : binRef(s));
    end
    drain();
  endtask

  always @(posedge ref_clk) begin
    if (!reset && clkEn && outValid === 1'b1) begin
      if (expQ.size() == 0) chk("outValid", 26'h0, 26'h1);
      else chk("outSample", expQ.pop_front(), outSample);
    end
  end

  initial begin
    int gT[5] = '{0, 1024, -2048, 2047, 291};
    int oT[5] = '{0, 0, 1, 2047, -2048};
    int uT[5] = '{4095, 2048, 0, 256, 4095};
    int lT[5] = '{0, 256, 0, 2048, 4095};
    logic [25:0] mT[4] = '{26'h0, 26'h2000000, 26'h0010000, 26'h0018000};
    int bS[10] = '{5000, 12300, 12238, 12240, 12100, 30000, 28600, 28700, -100, 1};
    logic [25:0] wv[32];
    logic [25:0] e;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADDR_CLAMP, '0);
    rd(ADDR_LIN_LAST, '0);
    rd(ADDR_TRIM, '0);
    for (int a = 7; a < 21; a++) begin
      wv[a] = 26'($random(seed));
      wr(7'(a), wv[a]);
    end
    for (int a = 7; a < 21; a++) begin
      e = (a == 8 || (a > 9 && a < 20)) ? wv[a] : '0;
      if (a == 8 || a == 19) e = e & 26'h0ffffff;
      rd(7'(a), e);
    end
    // Inversion bits must not act while the table is off
    ctl = 26'h0018000;
    wr(ADDR_LIN_LAST, ctl);
    for (int i = 0; i < 5; i++) begin
      setTrim(gT[i], oT[i]);
      setClamp(uT[i], lT[i]);
      burst(0);
    end
    setTrim(0, 0);
    setClamp(4095, 0);
    for (int m = 0; m < 8; m++) wr(7'(ADDR_LIN_FIRST + m), 26'(((32 * m + 16) << 13) | 32 * m));
    for (int i = 0; i < 4; i++) begin
      ctl = 26'h0002100 | mT[i];
      wr(ADDR_LIN_LAST, ctl);
      burst(1);
    end
    for (int m = 0; m < 4; m++) begin
      wr(7'(ADDR_LIN_FIRST + m), 26'(((4608 + 1024 * m) << 13) | (4096 + 1024 * m)));
      wr(7'(ADDR_LIN_FIRST + 4 + m), 26'(((4196 + 200 * m) << 13) | (4096 + 200 * m)));
    end
    ctl = 26'h0646000;
    wr(ADDR_LIN_LAST, ctl);
    stall <= 1'b1;
    for (int k = 0; k < 10; k++) send(bS[k], binRef(bS[k]));
    drain();
    burst(2);
    results();
  end
endmodule
